// ===== smc_defines.svh
// Constants for the switch port MAC control block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the port MAC module, the only file that includes it.
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH

// ==========================================================
// Register offsets
`define SMC_A_OPCTL 16'h0300
`define SMC_A_MAC0 16'h0330
`define SMC_A_MAC1 16'h0331
`define SMC_A_PTA 16'h03C0
`define SMC_A_PTB 16'h03C2
`define SMC_A_PTC 16'h03C4
`define SMC_A_SDADR 16'h7200
`define SMC_A_SDDAT 16'h7206
`define SMC_A_PCTL 16'h1403
`define SMC_A_PSTAT 16'h1410
`define SMC_A_PLATE 16'h1416

// ==========================================================
// Field positions
`define SMC_B_SOFTRST 1
`define SMC_B_NOEXC 3
`define SMC_B_ALTBO 7
`define SMC_B_LENCHK 3
`define SMC_B_CRSMODE 5
`define SMC_B_BPEN 6
`define SMC_B_LINKDIS 0
`define SMC_B_RLFC 3
`define SMC_B_SDRST 15

// ==========================================================
// Reset and init values
`define SMC_R_OPCTL 8'h00
`define SMC_R_MAC0 8'h00
`define SMC_R_MAC1 8'hF0
`define SMC_R_PT 16'h0000
`define SMC_R_PCTL 8'h00
`define SMC_R_SDADR 32'h0000_0000
`define SMC_R_SDCTL 16'h1140
`define SMC_SD_CTL_IDX 32'h001F_0000

// ==========================================================
// Pause tuning values needed on energy-efficient links
`define SMC_V_PTA 16'h4090
`define SMC_V_PTB 16'h0080
`define SMC_V_PTC 16'h2000

// ==========================================================
// Timing and frame figures (one byte per clock on the line side)
`define SMC_SLOT_BITS 512
`define SMC_BITS_PER_BYTE 8
`define SMC_SLOT_BYTES (`SMC_SLOT_BITS / `SMC_BITS_PER_BYTE)
`define SMC_JAM_BYTES 11'h004
`define SMC_ATT_LIMIT 5'h10
`define SMC_BO_KMAX 5'h0A
`define SMC_HDR_BYTES 11'h00E
`define SMC_FCS_BYTES 11'h004
`define SMC_LEN_B0 11'h00C
`define SMC_LEN_B1 11'h00D
`define SMC_MAX_LEN 16'h05DC
`define SMC_LFSR_SEED 16'hACE1
`define SMC_FIFO_DEPTH 8
`define SMC_DESC_W 11
`endif

// ===== smc_pkg.sv
// Types for the switch port MAC control block.
// Assumes smc_defines.svh is on the include path.
package smc_pkg;
  typedef enum logic [2:0]
  {
    TX_IDLE = 3'h0,
    TX_XMIT = 3'h1,
    TX_JAM = 3'h2,
    TX_BACKOFF = 3'h3,
    TX_LOCK = 3'h4
  } smc_tx_state_t;

  typedef enum logic [1:0]
  {
    SRC_SPI = 2'h0,
    SRC_I2C = 2'h1,
    SRC_INBAND = 2'h2,
    SRC_MIIM = 2'h3
  } smc_src_t;

  typedef enum logic [1:0]
  {
    SZ_8 = 2'h0,
    SZ_16 = 2'h1,
    SZ_32 = 2'h2
  } smc_size_t;
endpackage

// ===== smc_fifo.sv
// Descriptor FIFO with valid/ready on both sides; full registered, empty decoded from the level count.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module smc_fifo #(
  parameter int W = 11,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_clr,
  // Fill side
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_valid = (cnt_reg != '0);
  assign o_data = mem[rp_reg];

  // ==========================================================
  // Storage
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wp_reg] <= i_data;
    end
  end

  // ==========================================================
  // Pointers and level; full kept in a flop so ready is glitch free
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      o_ready <= 1'b1;
    end
    else if (i_clr)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      o_ready <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (pop)
      begin
        rp_reg <= rp_reg + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_reg <= cnt_reg + 1'b1;
        o_ready <= (cnt_reg != (AW + 1)'(D - 1));
      end
      else if (pop && !push)
      begin
        cnt_reg <= cnt_reg - 1'b1;
        o_ready <= 1'b1;
      end
    end
  end
endmodule

// ===== smc_port_mac.sv
// Switch port MAC control: global config, half-duplex transmit, receive checks.
// Assumes management transfers arrive as single-cycle strobes on I_MCLK.
`timescale 1ns/1ps
`include "smc_defines.svh"
module smc_port_mac (
  // Clock and resets
  input wire logic I_MCLK,
  input wire logic I_NRST,
  input wire logic I_NPOR,
  // Management access
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [1:0] I_REG_SRC,
  input wire logic [1:0] I_REG_SIZE,
  input wire logic [15:0] I_REG_ADDR,
  input wire logic [31:0] I_REG_WDATA,
  output logic [31:0] O_REG_RDATA,
  output logic O_REG_RVALID,
  output logic O_REG_WERR,
  // Line status pins
  input wire logic I_LINK_UP,
  input wire logic I_HALF_DUPLEX,
  input wire logic I_SPEED_100,
  input wire logic I_CRS,
  input wire logic I_COL,
  input wire logic I_EEE_ACTIVE,
  // Transmit descriptors
  input wire logic I_TX_VALID,
  input wire logic [10:0] I_TX_LEN,
  output logic O_TX_READY,
  // Transmit line
  output logic O_TX_EN,
  output logic O_TX_JAM,
  output logic O_TX_CARRIER,
  output logic O_TX_DONE,
  output logic O_TX_DROP,
  output logic O_TX_LOCKED,
  // Receive stream and ingress control
  input wire logic I_RX_VALID,
  input wire logic [7:0] I_RX_DATA,
  input wire logic I_RX_SOF,
  input wire logic I_RX_EOF,
  input wire logic I_RATE_EXCEEDED,
  input wire logic I_BP_REQ,
  output logic O_RX_ACCEPT,
  output logic O_RX_DROP,
  output logic O_PAUSE_REQ,
  // Serdes
  output logic O_SERDES_RST
);
  localparam int NS = 6;
  logic [NS-1:0] s1_reg;
  logic [NS-1:0] s2_reg;
  logic [NS-1:0] s3_reg;
  logic [NS-1:0] pin_reg;
  logic link;
  logic half;
  logic spd100;
  logic crs;
  logic col;
  logic eee;
  logic [7:0] opctl_reg;
  logic [7:0] mac0_reg;
  logic [7:0] mac1_reg;
  logic [15:0] pta_reg;
  logic [15:0] ptb_reg;
  logic [15:0] ptc_reg;
  logic [7:0] pctl_reg;
  logic [31:0] sdadr_reg;
  logic [15:0] sdctl_reg;
  logic clr_reg;
  logic wr_ok;
  logic [31:0] late_cnt_reg;
  smc_pkg::smc_tx_state_t st_reg;
  logic [10:0] byte_cnt_reg;
  logic [4:0] att_reg;
  logic [15:0] bo_cnt_reg;
  logic retry_reg;
  logic pop_reg;
  logic down_seen_reg;
  logic [15:0] lfsr_reg;
  logic f_valid;
  logic [10:0] f_len;
  logic [4:0] k;
  logic [9:0] slots;
  logic [15:0] bo_load;
  logic bp_active;
  logic pause_ok;
  logic [10:0] rx_cnt_reg;
  logic [15:0] lenf_reg;
  logic rate_hit_reg;
  logic [10:0] rx_total;
  logic [10:0] rx_data_len;
  logic rx_is_len;
  logic rx_bad_len;

  // ==========================================================
  // Pin synchronisers; a change is taken once stages two and three agree
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      pin_reg <= '0;
    end
    else
    begin
      s1_reg <= {I_EEE_ACTIVE, I_COL, I_CRS, I_SPEED_100, I_HALF_DUPLEX, I_LINK_UP};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < NS; i++)
      begin
        if (s2_reg[i] == s3_reg[i])
        begin
          pin_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  // Link may also be taken down by register control
  assign link = pin_reg[0] && !pctl_reg[`SMC_B_LINKDIS];
  assign half = pin_reg[1];
  assign spd100 = pin_reg[2];
  assign crs = pin_reg[3];
  assign col = pin_reg[4];
  assign eee = pin_reg[5];

  // ==========================================================
  // Global and port registers
  assign wr_ok = I_REG_WR && (I_REG_SRC != smc_pkg::SRC_MIIM);

  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      opctl_reg <= `SMC_R_OPCTL;
      mac0_reg <= `SMC_R_MAC0;
      mac1_reg <= `SMC_R_MAC1;
      pta_reg <= `SMC_R_PT;
      ptb_reg <= `SMC_R_PT;
      ptc_reg <= `SMC_R_PT;
      pctl_reg <= `SMC_R_PCTL;
      clr_reg <= 1'b0;
    end
    else if (clr_reg)
    begin
      // Soft reset spares the serdes registers
      opctl_reg <= `SMC_R_OPCTL;
      mac0_reg <= `SMC_R_MAC0;
      mac1_reg <= `SMC_R_MAC1;
      pta_reg <= `SMC_R_PT;
      ptb_reg <= `SMC_R_PT;
      ptc_reg <= `SMC_R_PT;
      pctl_reg <= `SMC_R_PCTL;
      clr_reg <= 1'b0;
    end
    else if (wr_ok)
    begin
      if (I_REG_ADDR == `SMC_A_OPCTL)
      begin
        opctl_reg <= I_REG_WDATA[7:0];
        clr_reg <= I_REG_WDATA[`SMC_B_SOFTRST];
      end
      else if (I_REG_ADDR == `SMC_A_MAC0)
      begin
        mac0_reg <= I_REG_WDATA[7:0];
      end
      else if (I_REG_ADDR == `SMC_A_MAC1)
      begin
        mac1_reg <= I_REG_WDATA[7:0];
      end
      else if (I_REG_ADDR == `SMC_A_PTA)
      begin
        pta_reg <= I_REG_WDATA[15:0];
      end
      else if (I_REG_ADDR == `SMC_A_PTB)
      begin
        ptb_reg <= I_REG_WDATA[15:0];
      end
      else if (I_REG_ADDR == `SMC_A_PTC)
      begin
        ptc_reg <= I_REG_WDATA[15:0];
      end
      else if (I_REG_ADDR == `SMC_A_PCTL)
      begin
        pctl_reg <= I_REG_WDATA[7:0];
      end
    end
  end

  // ==========================================================
  // Serdes indirect window; only the power-on reset reaches it
  always_ff @(posedge I_MCLK or negedge I_NPOR)
  begin
    if (!I_NPOR)
    begin
      sdadr_reg <= `SMC_R_SDADR;
      sdctl_reg <= `SMC_R_SDCTL;
      O_SERDES_RST <= 1'b0;
    end
    else
    begin
      O_SERDES_RST <= 1'b0;
      if (wr_ok && I_REG_ADDR == `SMC_A_SDADR && I_REG_SIZE == smc_pkg::SZ_32)
      begin
        sdadr_reg <= I_REG_WDATA;
      end
      else if (wr_ok && I_REG_ADDR == `SMC_A_SDDAT && I_REG_SIZE == smc_pkg::SZ_16
        && sdadr_reg == `SMC_SD_CTL_IDX)
      begin
        if (I_REG_WDATA[`SMC_B_SDRST])
        begin
          sdctl_reg <= `SMC_R_SDCTL;
          O_SERDES_RST <= 1'b1;
        end
        else
        begin
          sdctl_reg <= I_REG_WDATA[15:0];
        end
      end
    end
  end

  // ==========================================================
  // Read side and refused-write flag
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_REG_RDATA <= '0;
      O_REG_RVALID <= 1'b0;
      O_REG_WERR <= 1'b0;
    end
    else
    begin
      O_REG_RVALID <= I_REG_RD;
      O_REG_WERR <= I_REG_WR && (I_REG_SRC == smc_pkg::SRC_MIIM);
      if (I_REG_RD)
      begin
        if (I_REG_ADDR == `SMC_A_OPCTL)
        begin
          O_REG_RDATA <= {24'h000000, opctl_reg};
        end
        else if (I_REG_ADDR == `SMC_A_MAC0)
        begin
          O_REG_RDATA <= {24'h000000, mac0_reg};
        end
        else if (I_REG_ADDR == `SMC_A_MAC1)
        begin
          O_REG_RDATA <= {24'h000000, mac1_reg};
        end
        else if (I_REG_ADDR == `SMC_A_PTA)
        begin
          O_REG_RDATA <= {16'h0000, pta_reg};
        end
        else if (I_REG_ADDR == `SMC_A_PTB)
        begin
          O_REG_RDATA <= {16'h0000, ptb_reg};
        end
        else if (I_REG_ADDR == `SMC_A_PTC)
        begin
          O_REG_RDATA <= {16'h0000, ptc_reg};
        end
        else if (I_REG_ADDR == `SMC_A_PCTL)
        begin
          O_REG_RDATA <= {24'h000000, pctl_reg};
        end
        else if (I_REG_ADDR == `SMC_A_PSTAT)
        begin
          O_REG_RDATA <= {26'h0000000, eee, O_TX_LOCKED, spd100, half, pin_reg[0], link};
        end
        else if (I_REG_ADDR == `SMC_A_PLATE)
        begin
          O_REG_RDATA <= late_cnt_reg;
        end
        else if (I_REG_ADDR == `SMC_A_SDADR)
        begin
          O_REG_RDATA <= sdadr_reg;
        end
        else if (I_REG_ADDR == `SMC_A_SDDAT && sdadr_reg == `SMC_SD_CTL_IDX)
        begin
          O_REG_RDATA <= {16'h0000, sdctl_reg};
        end
        else
        begin
          O_REG_RDATA <= '0;
        end
      end
    end
  end

  // ==========================================================
  // Descriptor FIFO; its ready is the block's ready to the switch core
  smc_fifo #(
    .W(`SMC_DESC_W),
    .D(`SMC_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_MCLK),
    .i_nrst(I_NRST),
    .i_clr(clr_reg),
    .i_valid(I_TX_VALID),
    .i_data(I_TX_LEN),
    .o_ready(O_TX_READY),
    .o_valid(f_valid),
    .o_data(f_len),
    .i_ready(pop_reg)
  );

  // ==========================================================
  // Back-off: alternate mode draws from other LFSR bits to break lock-step
  assign k = (att_reg > `SMC_BO_KMAX) ? `SMC_BO_KMAX : att_reg;
  assign slots = (mac0_reg[`SMC_B_ALTBO] ? lfsr_reg[15:6] : lfsr_reg[9:0])
    & 10'((11'h001 << k) - 11'h001);
  assign bo_load = 16'(slots * `SMC_SLOT_BYTES);

  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      lfsr_reg <= `SMC_LFSR_SEED;
    end
    else
    begin
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    end
  end

  // ==========================================================
  // Half-duplex transmit engine, one byte per clock; one instance per port
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      st_reg <= smc_pkg::TX_IDLE;
      byte_cnt_reg <= '0;
      att_reg <= '0;
      bo_cnt_reg <= '0;
      retry_reg <= 1'b0;
      pop_reg <= 1'b0;
      down_seen_reg <= 1'b0;
      late_cnt_reg <= '0;
      O_TX_DONE <= 1'b0;
      O_TX_DROP <= 1'b0;
    end
    else if (clr_reg)
    begin
      st_reg <= smc_pkg::TX_IDLE;
      byte_cnt_reg <= '0;
      att_reg <= '0;
      retry_reg <= 1'b0;
      pop_reg <= 1'b0;
      down_seen_reg <= 1'b0;
      late_cnt_reg <= '0;
      O_TX_DONE <= 1'b0;
      O_TX_DROP <= 1'b0;
    end
    else
    begin
      pop_reg <= 1'b0;
      O_TX_DONE <= 1'b0;
      O_TX_DROP <= 1'b0;
      case (st_reg)
        smc_pkg::TX_IDLE:
        begin
          // pop_reg guard: head still shows the frame just retired
          if (link && f_valid && !pop_reg && !(half && crs))
          begin
            st_reg <= smc_pkg::TX_XMIT;
            byte_cnt_reg <= '0;
          end
        end
        smc_pkg::TX_XMIT:
        begin
          byte_cnt_reg <= byte_cnt_reg + 11'h001;
          if (!link)
          begin
            st_reg <= smc_pkg::TX_IDLE;
          end
          else if (half && col)
          begin
            st_reg <= smc_pkg::TX_JAM;
            byte_cnt_reg <= '0;
            if (byte_cnt_reg >= 11'(`SMC_SLOT_BYTES))
            begin
              late_cnt_reg <= late_cnt_reg + 32'h0000_0001;
              retry_reg <= 1'b0;
              pop_reg <= 1'b1;
              O_TX_DROP <= 1'b1;
              att_reg <= '0;
            end
            else if (att_reg + 5'h01 == `SMC_ATT_LIMIT)
            begin
              att_reg <= '0;
              if (!opctl_reg[`SMC_B_NOEXC])
              begin
                retry_reg <= 1'b0;
                pop_reg <= 1'b1;
                O_TX_DROP <= 1'b1;
              end
              else if (mac0_reg[`SMC_B_ALTBO])
              begin
                retry_reg <= 1'b1;
              end
              else
              begin
                st_reg <= smc_pkg::TX_LOCK;
                down_seen_reg <= 1'b0;
              end
            end
            else
            begin
              att_reg <= att_reg + 5'h01;
              retry_reg <= 1'b1;
            end
          end
          else if (byte_cnt_reg + 11'h001 >= f_len)
          begin
            st_reg <= smc_pkg::TX_IDLE;
            pop_reg <= 1'b1;
            O_TX_DONE <= 1'b1;
            att_reg <= '0;
          end
        end
        smc_pkg::TX_JAM:
        begin
          byte_cnt_reg <= byte_cnt_reg + 11'h001;
          if (byte_cnt_reg + 11'h001 >= `SMC_JAM_BYTES)
          begin
            st_reg <= retry_reg ? smc_pkg::TX_BACKOFF : smc_pkg::TX_IDLE;
            bo_cnt_reg <= bo_load;
          end
        end
        smc_pkg::TX_BACKOFF:
        begin
          if (bo_cnt_reg == '0)
          begin
            st_reg <= smc_pkg::TX_IDLE;
          end
          else
          begin
            bo_cnt_reg <= bo_cnt_reg - 16'h0001;
          end
        end
        smc_pkg::TX_LOCK:
        begin
          // Only a full link down and up, or a soft reset, releases it
          if (!link)
          begin
            down_seen_reg <= 1'b1;
          end
          else if (down_seen_reg)
          begin
            st_reg <= smc_pkg::TX_IDLE;
            down_seen_reg <= 1'b0;
          end
        end
        default:
        begin
          st_reg <= smc_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Line drive and back pressure
  assign bp_active = I_BP_REQ && mac1_reg[`SMC_B_BPEN] && half && spd100 && link;

  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_TX_EN <= 1'b0;
      O_TX_JAM <= 1'b0;
      O_TX_CARRIER <= 1'b0;
      O_TX_LOCKED <= 1'b0;
    end
    else
    begin
      O_TX_EN <= (st_reg == smc_pkg::TX_XMIT);
      O_TX_LOCKED <= (st_reg == smc_pkg::TX_LOCK);
      // Carrier mode holds the wire busy; can trip jabber on long holds
      O_TX_CARRIER <= bp_active && mac1_reg[`SMC_B_CRSMODE]
        && (st_reg == smc_pkg::TX_IDLE);
      O_TX_JAM <= (st_reg == smc_pkg::TX_JAM)
        || (bp_active && !mac1_reg[`SMC_B_CRSMODE] && crs);
    end
  end

  // ==========================================================
  // Receive checks: length field and ingress rate limit
  assign pause_ok = !eee || (pta_reg == `SMC_V_PTA && ptb_reg == `SMC_V_PTB
    && ptc_reg == `SMC_V_PTC);
  assign rx_total = rx_cnt_reg + 11'h001;
  assign rx_data_len = rx_total - `SMC_HDR_BYTES - `SMC_FCS_BYTES;
  assign rx_is_len = (lenf_reg <= `SMC_MAX_LEN);
  assign rx_bad_len = mac0_reg[`SMC_B_LENCHK] && rx_is_len
    && ((rx_total < `SMC_HDR_BYTES + `SMC_FCS_BYTES)
    || ({5'h00, rx_data_len} != lenf_reg));

  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      rx_cnt_reg <= '0;
      lenf_reg <= '0;
      rate_hit_reg <= 1'b0;
      O_RX_ACCEPT <= 1'b0;
      O_RX_DROP <= 1'b0;
      O_PAUSE_REQ <= 1'b0;
    end
    else
    begin
      O_RX_ACCEPT <= 1'b0;
      O_RX_DROP <= 1'b0;
      O_PAUSE_REQ <= I_RATE_EXCEEDED && pctl_reg[`SMC_B_RLFC] && pause_ok && link;
      if (I_RX_VALID)
      begin
        rx_cnt_reg <= I_RX_SOF ? 11'h001 : rx_cnt_reg + 11'h001;
        if (I_RX_SOF)
        begin
          rate_hit_reg <= I_RATE_EXCEEDED;
        end
        else if (I_RATE_EXCEEDED)
        begin
          rate_hit_reg <= 1'b1;
        end
        if (!I_RX_SOF && rx_cnt_reg == `SMC_LEN_B0)
        begin
          lenf_reg[15:8] <= I_RX_DATA;
        end
        if (!I_RX_SOF && rx_cnt_reg == `SMC_LEN_B1)
        begin
          lenf_reg[7:0] <= I_RX_DATA;
        end
        if (I_RX_EOF)
        begin
          // With flow control on, the limiter never drops
          if (rx_bad_len || (rate_hit_reg && !pctl_reg[`SMC_B_RLFC]))
          begin
            O_RX_DROP <= 1'b1;
          end
          else
          begin
            O_RX_ACCEPT <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// ===== smc_mac_asserts.sv
// Checker for the port MAC control block ports.
// Assumes it is bound to smc_port_mac.
`timescale 1ns/1ps
module smc_mac_asserts (
  input wire logic I_MCLK, I_NRST, I_REG_WR, I_REG_RD, I_RATE_EXCEEDED, I_RX_VALID, I_RX_EOF,
  input wire logic [1:0] I_REG_SRC,
  input wire logic [15:0] I_REG_ADDR,
  input wire logic O_REG_RVALID, O_REG_WERR, O_SERDES_RST, O_PAUSE_REQ, O_RX_ACCEPT,
  input wire logic O_RX_DROP, O_TX_EN, O_TX_DONE, O_TX_DROP, O_TX_LOCKED
);
  // ====
  // Properties
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_NRST);
  miim_refused_a: assert property (I_REG_WR && I_REG_SRC == 2'h3 |=> O_REG_WERR)
    else $error("miim write kept");
  werr_cause_a: assert property (O_REG_WERR |-> $past(I_REG_WR && I_REG_SRC == 2'h3))
    else $error("stray write error");
  read_answer_a: assert property (I_REG_RD |=> O_REG_RVALID)
    else $error("read unanswered");
  serdes_pulse_a: assert property (O_SERDES_RST |=> !O_SERDES_RST)
    else $error("serdes reset too long");
  serdes_cause_a: assert property (O_SERDES_RST |-> $past(I_REG_ADDR == 16'h7206))
    else $error("serdes reset without data write");
  pause_cause_a: assert property (O_PAUSE_REQ |-> $past(I_RATE_EXCEEDED))
    else $error("pause without excess");
  rx_verdict_a: assert property (O_RX_ACCEPT || O_RX_DROP |->
    $past(I_RX_VALID && I_RX_EOF))
    else $error("verdict without frame end");
  lock_quiet_a: assert property (O_TX_LOCKED |-> !O_TX_EN)
    else $error("sending while locked");
  // Done comes with the last byte; the enable falls one cycle later
  done_end_a: assert property (O_TX_DONE |-> O_TX_EN && !O_TX_DROP ##1 !O_TX_EN)
    else $error("done misplaced");
  cover property (O_TX_DROP);
  cover property (O_SERDES_RST);
  cover property (O_RX_DROP);
endmodule

// ===== smc_peer.sv
// Half-duplex link peer: one collision per arming at a chosen byte, carrier on demand.
// Assumes one transmit byte per clock.
`timescale 1ns/1ps
module smc_peer (
  input wire logic clk,
  input wire logic arm,
  input wire logic tx_en,
  input wire logic [10:0] col_at,
  input wire logic talk,
  output logic crs,
  output logic col
);
  logic [10:0] n = 11'h000;
  logic was = 1'b0;
  logic hit = 1'b0;
  always @(posedge clk)
  begin
    n <= tx_en ? n + 11'h001 : 11'h000;
    was <= col;
    hit <= arm && (hit || (was && !tx_en));
  end
  // Held until the device stops, so its pin filter sees it
  assign col = arm && !hit && tx_en && (n >= col_at);
  // Carrier also while the peer sends, so collision back pressure has a cause
  assign crs = col || talk;
endmodule

// ===== tb_top.sv
// Testbench for the port MAC control block.
// Assumes the design, checker and peer files are compiled first.
`timescale 1ns/1ps
module tb_top;
  logic I_MCLK = 0, I_NRST = 0, I_NPOR = 0, I_REG_WR = 0, I_REG_RD = 0, I_LINK_UP = 0;
  logic I_HALF_DUPLEX = 1, I_SPEED_100 = 1, I_EEE_ACTIVE = 0, I_TX_VALID = 0, I_RX_VALID = 0;
  logic I_RX_SOF = 0, I_RX_EOF = 0, I_RATE_EXCEEDED = 0, I_BP_REQ = 0, arm = 0, I_CRS, I_COL;
  logic [1:0] I_REG_SRC = 0, I_REG_SIZE = 0;
  logic [15:0] I_REG_ADDR = 0;
  logic [31:0] I_REG_WDATA = 0, O_REG_RDATA;
  logic [31:0] pv [3] = '{32'h4090, 32'h80, 32'h2000};
  logic [10:0] I_TX_LEN = 0, col_at = 0;
  logic [7:0] I_RX_DATA = 0;
  logic talk = 0;
  logic O_REG_RVALID, O_REG_WERR, O_TX_READY, O_TX_EN, O_TX_JAM, O_TX_CARRIER, O_TX_DONE;
  logic O_TX_DROP, O_TX_LOCKED, O_RX_ACCEPT, O_RX_DROP, O_PAUSE_REQ, O_SERDES_RST;
  int failures = 0, comparisons = 0, cyc = 0, k, cnt = 0, en_cnt = 0;
  smc_port_mac dut (.*);
  smc_peer peer (.clk(I_MCLK), .arm(arm), .tx_en(O_TX_EN), .col_at(col_at), .crs(I_CRS),
    .talk(talk), .col(I_COL));
  initial forever #50 I_MCLK = ~I_MCLK;
  // ====
  // Access tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [1:0] s, z, input logic [15:0] a, input logic [31:0] d);
    @(negedge I_MCLK);
    {I_REG_WR, I_REG_SRC, I_REG_SIZE, I_REG_ADDR, I_REG_WDATA} = {1'b1, s, z, a, d};
    @(negedge I_MCLK);
    I_REG_WR = 0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(negedge I_MCLK);
    {I_REG_RD, I_REG_ADDR} = {1'b1, a};
    @(negedge I_MCLK);
    I_REG_RD = 0;
    chk({O_REG_RVALID, O_REG_RDATA[30:0]}, {1'b1, e[30:0]});
  endtask
  task automatic rx(input logic [15:0] f, input logic [1:0] e);
    for (k = 0; k < 64; k++)
    begin
      @(negedge I_MCLK);
      {I_RX_VALID, I_RX_SOF, I_RX_EOF} = {1'b1, k == 0, k == 63};
      I_RX_DATA = (k == 12) ? f[15:8] : (k == 13) ? f[7:0] : 8'(k);
    end
    @(negedge I_MCLK);
    I_RX_VALID = 0;
    chk({O_RX_ACCEPT, O_RX_DROP}, e);
  endtask
  task automatic tx(input logic [10:0] n, input logic [1:0] e);
    @(negedge I_MCLK);
    {I_TX_VALID, I_TX_LEN} = {1'b1, n};
    @(negedge I_MCLK);
    I_TX_VALID = 0;
    for (k = 0; k < 3000 && !(O_TX_DONE || O_TX_DROP); k++) @(negedge I_MCLK);
    chk({O_TX_DONE, O_TX_DROP}, e);
  endtask
  task automatic bp(input logic [1:0] e);
    {I_BP_REQ, talk} = 2'b11;
    repeat (6) @(negedge I_MCLK);
    chk({O_TX_CARRIER, O_TX_JAM}, e);
    {I_BP_REQ, talk} = 2'b00;
    repeat (6) @(negedge I_MCLK);
  endtask
  task automatic close_out;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ====
  // Sequence
  initial
  begin
    repeat (4) @(negedge I_MCLK);
    {I_NRST, I_NPOR} = 2'b11;
    rd(16'h0300, 32'h0);
    rd(16'h2000, 32'h0);
    wr(2'h3, 2'h0, 16'h0330, 32'h88);
    chk(O_REG_WERR, 1'b1);
    rd(16'h0330, 32'h0);
    wr(2'h1, 2'h0, 16'h0330, 32'h80);
    rd(16'h0330, 32'h80);
    for (int i = 0; i < 3; i++) wr(2'h2, 2'h1, 16'h03C0 + 16'(2 * i), pv[i]);
    for (int i = 0; i < 3; i++) rd(16'h03C0 + 16'(2 * i), pv[i]);
    I_TX_LEN = 11'h004;
    I_TX_VALID = 1;
    repeat (12) @(negedge I_MCLK);
    chk(O_TX_READY, 1'b0);
    {I_TX_VALID, I_LINK_UP} = 2'b01;
    for (int i = 0; i < 400; i++)
    begin
      @(negedge I_MCLK);
      cnt += O_TX_DONE;
      en_cnt += O_TX_EN;
    end
    chk(cnt, 8);
    chk(en_cnt, 32'h20);
    bp(2'b10);
    wr(2'h0, 2'h0, 16'h0331, 32'hD0);
    rd(16'h0331, 32'hD0);
    bp(2'b01);
    {arm, col_at} = {1'b1, 11'h005};
    tx(11'h064, 2'b10);
    arm = 0;
    @(negedge I_MCLK);
    {arm, col_at} = {1'b1, 11'h046};
    tx(11'h064, 2'b01);
    rd(16'h1416, 32'h1);
    I_HALF_DUPLEX = 0;
    wr(2'h0, 2'h0, 16'h0330, 32'h88);
    rx(16'h002E, 2'b10);
    rx(16'h0028, 2'b01);
    rx(16'h0800, 2'b10);
    wr(2'h0, 2'h0, 16'h0330, 32'h80);
    rx(16'h0028, 2'b10);
    rd(16'h1410, 32'h0B);
    wr(2'h2, 2'h0, 16'h1403, 32'h08);
    {I_RATE_EXCEEDED, I_EEE_ACTIVE} = 2'b11;
    rx(16'h0800, 2'b10);
    chk(O_PAUSE_REQ, 1'b1);
    I_RATE_EXCEEDED = 0;
    wr(2'h0, 2'h2, 16'h7200, 32'h001F0000);
    wr(2'h0, 2'h1, 16'h7206, 32'h9140);
    chk(O_SERDES_RST, 1'b1);
    rd(16'h7206, 32'h1140);
    wr(2'h0, 2'h1, 16'h7206, 32'h1100);
    wr(2'h0, 2'h0, 16'h7206, 32'h1000);
    rd(16'h7206, 32'h1100);
    wr(2'h0, 2'h0, 16'h0300, 32'h02);
    repeat (2) @(negedge I_MCLK);
    rd(16'h0331, 32'hF0);
    rd(16'h1416, 32'h0);
    wr(2'h0, 2'h0, 16'h0331, 32'hD0);
    I_NRST = 0;
    @(negedge I_MCLK);
    I_NRST = 1;
    rd(16'h0331, 32'hF0);
    rd(16'h7206, 32'h1100);
    I_NPOR = 0;
    @(negedge I_MCLK);
    I_NPOR = 1;
    wr(2'h0, 2'h2, 16'h7200, 32'h001F0000);
    rd(16'h7206, 32'h1140);
    close_out;
  end
  always @(posedge I_MCLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      close_out;
    end
  end
endmodule
bind smc_port_mac smc_mac_asserts u_chk (.*);
